// ==== logic/ecwl_filter.sv ====
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Lock word is 16 bits at command DDh
// - Bit 15 always reads zero, holds nothing
// - Bit 14 freezes 10h, DDh; only a load clears
// - Bit 13 blocks trim group writes
// - Bit 12 blocks output voltage mode, setpoint
// - Bit 11 blocks output max/min and OV/UV faults
// - Bit 10 blocks warning configuration writes
// - Bit 9 blocks current, temperature fault writes
// - Bit 8 blocks margin and transition rate
// - Bit 7 blocks OPERATION writes
// - Bit 6 blocks device configuration writes
// - Bit 5 blocks input overvoltage fault limit
// - Bit 4 blocks sequencing command writes
// - Bit 3 blocks maker identity data writes
// - Bit 2 blocks security key command
// - Bit 1 blocks host restore; power-up load stays
// - Bit 0 store lock acts after load only
// - Clear bit accepts unless standard protect forbids
module ecwl_filter (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic        cmd_wr_in,
	input  wire logic        cmd_rd_in,
	input  wire logic [7:0]  cmd_code_in,
	input  wire logic [15:0] cmd_wdata_in,
	input  wire logic        std_wp_ro_in,
	input  wire logic        nvm_load_in,
	input  wire logic [15:0] nvm_word_in,
	output logic             wr_accept_out,
	output logic             wr_reject_out,
	output logic      [3:0]  reject_cause_out,
	output logic             rd_valid_out,
	output logic      [15:0] rd_data_out,
	output logic      [15:0] lock_word_out,
	output logic             store_lock_active_out
);

	// Overview: every host write is held against the lock bit that
	// guards its command and against the standard protect input. The
	// verdict comes one clock later as an accept or a reject pulse, and
	// the target register only stores on an accept.
	// The lock word lives here. A load pulse from memory fills it, and
	// the host writes it through its own command code.
	// The store lock is the odd one out: it acts from a loaded copy,
	// so a host can set it and still store the word that carries it.
	// Reads of the lock word answer one clock later with a strobe.
	// Nothing here is clock gated; all state runs on every edge.

	// Lock hits and the verdict they lead to; the per-bit vectors are
	// nets because a generate loop drives them one bit at a time
	logic      [15:0] guard_sel;
	wire logic [15:0] active_locks;
	wire logic [15:0] lock_hit;
	logic             group_blocked;
	logic      [3:0]  group_cause;

	// Request decode, shared by the lock and read paths
	logic        wr_lock_word;
	logic        rd_lock_word;
	logic        lock_wr_ok;
	logic        protect_held;

	// Lock state: bits 14..0 as written or loaded, and the loaded
	// copy of the store lock that really governs the store command
	logic [14:0] lock_r;
	logic [14:0] lock_nxt;
	logic        store_eff_r;
	logic        store_eff_nxt;

	// Verdict flops: one-cycle pulses and a cause that holds
	logic        accept_r;
	logic        accept_nxt;
	logic        reject_r;
	logic        reject_nxt;
	logic [3:0]  cause_r;
	logic [3:0]  cause_nxt;
	// Read answer: a one-cycle strobe and data that holds
	logic        rd_valid_r;
	logic        rd_valid_nxt;
	logic [15:0] rd_data_r;
	logic [15:0] rd_data_nxt;

	// True for the command code of the lock word itself; shared by
	// the write path and the read path
	function automatic logic is_lock_word(input logic [7:0] code);
		return code == ecwl_pkg::CMD_LOCK_WORD;
	endfunction

	// Lock word as the host sees it: bit 15 is always zero. Used by
	// the read port and by the lock word output alike.
	function automatic logic [15:0] lock_image(input logic [14:0] bits);
		return {1'b0, bits};
	endfunction

	// Index of the highest hit, or CAUSE_NONE when nothing hits. The
	// decoder is one-hot, so the priority order never matters in use.
	function automatic logic [3:0] top_index(input logic [15:0] hits);
		logic [3:0] idx;
		idx = ecwl_pkg::CAUSE_NONE;
		for (int i = 0; i < ecwl_pkg::LW_WIDTH; i++) begin
			if (hits[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	// Guard groups by lock bit, with the codes the decoder maps:
	//   15  none; spare bit, always reads zero
	//   14  standard protect 10h and this lock word DDh
	//   13  output trim 22h, monitor gain A4h, scale loop 29h,
	//       scale monitor 2Ah, boot offset E0h
	//   12  output voltage mode 20h, setpoint 21h
	//   11  output max 24h, output min 2Bh,
	//       overvoltage fault limit and response 40h, 41h,
	//       undervoltage fault limit and response 44h, 45h
	//   10  alert mask 1Bh, output over/under warnings 42h, 43h,
	//       overcurrent warning 4Ah, overtemperature warning 51h
	//    9  overcurrent fault limit and response 46h, 47h,
	//       overtemperature fault limit and response 4Fh, 50h
	//    8  margin high 25h, margin low 26h, transition rate 27h
	//    7  operation 01h
	//    6  switching frequency 33h, system config E1h,
	//       bus address E2h, compensation E3h, stacking E4h
	//    5  input overvoltage fault limit 55h
	//    4  turn-on delay and rise 60h, 61h, turn-off delay and
	//       fall 64h, 65h, on/off config 02h, input on/off 35h, 36h
	//    3  maker identity, model and revision 99h, 9Ah, 9Bh
	//    2  security key 0Eh
	//    1  host restore 16h; the memory load is never blocked
	//    0  host store 15h, from the loaded copy only
	// Codes outside these groups pass unless standard protect refuses.

	// Which lock bit guards the command being written
	ecwl_group_decode u_decode (
		.cmd_code_in   (cmd_code_in),
		.guard_sel_out (guard_sel)
	);

	// Locks in force now, built bit by bit: bit 15 is spare, bit 0
	// takes the loaded store copy, the rest act as soon as written.
	// A hit means the command is in a group that is locked now.
	generate
		for (genvar g = 0; g < ecwl_pkg::LW_WIDTH; g++) begin : g_lock
			if (g == ecwl_pkg::BIT_ZERO) begin : g_spare
				assign active_locks[g] = 1'b0;
				assign lock_hit[g] = 1'b0;
			end else if (g == ecwl_pkg::BIT_STORE) begin : g_store
				assign active_locks[g] = store_eff_r;
				assign lock_hit[g] = guard_sel[g] & active_locks[g];
			end else begin : g_live
				assign active_locks[g] = lock_r[g];
				assign lock_hit[g] = guard_sel[g] & active_locks[g];
			end
		end
	endgenerate

	// Any hit refuses the write; the cause names the guarding bit
	always_comb begin
		group_blocked = |lock_hit;
		group_cause = top_index(lock_hit);
	end

	// Request decode; protect_held is the sticky bit 14 as stored
	always_comb begin
		wr_lock_word = cmd_wr_in && is_lock_word(cmd_code_in);
		rd_lock_word = cmd_rd_in && is_lock_word(cmd_code_in);
		protect_held = lock_r[ecwl_pkg::BIT_PROTECT];
		lock_wr_ok = wr_lock_word && !group_blocked && !std_wp_ro_in;
	end

	// Lock bits: a load from memory wins over a host write, since a
	// restore must see the stored image and not a stale bus value.
	// The load is never refused, not even with the restore lock set.
	always_comb begin
		lock_nxt = lock_r;
		if (nvm_load_in) begin
			lock_nxt = nvm_word_in[14:0];
		end else if (lock_wr_ok) begin
			// Bit 14 is clear here, since it guards this very word; the
			// OR keeps it sticky even if that guard were ever bypassed
			lock_nxt = cmd_wdata_in[14:0];
			lock_nxt[ecwl_pkg::BIT_PROTECT] = protect_held
				| cmd_wdata_in[ecwl_pkg::BIT_PROTECT];
		end
	end

	// Lock bits register
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			lock_r <= ecwl_pkg::LW_RESET[14:0];
		end else begin
			lock_r <= lock_nxt;
		end
	end

	// Store lock in force: only a memory load copies bit 0 across.
	// A host write of bit 0 shows in the lock word at once, but the
	// store command stays open until the word is stored and loaded.
	always_comb begin
		store_eff_nxt = store_eff_r;
		if (nvm_load_in) begin
			store_eff_nxt = nvm_word_in[ecwl_pkg::BIT_STORE];
		end
	end

	// Loaded store lock register
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			store_eff_r <= ecwl_pkg::LW_RESET[ecwl_pkg::BIT_STORE];
		end else begin
			store_eff_r <= store_eff_nxt;
		end
	end

	// Write verdict: a group lock or standard protect refuses it.
	// A refused write only raises a flag; the target keeps its value
	// because it never sees an accept pulse for that write.
	always_comb begin
		accept_nxt = 1'b0;
		reject_nxt = 1'b0;
		if (cmd_wr_in) begin
			if (group_blocked || std_wp_ro_in) begin
				reject_nxt = 1'b1;
			end else begin
				accept_nxt = 1'b1;
			end
		end
	end

	// Covers every group
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			accept_r <= 1'b0;
			reject_r <= 1'b0;
		end else begin
			accept_r <= accept_nxt;
			reject_r <= reject_nxt;
		end
	end

	// Cause of the last refusal holds until the next one, so that the
	// status logic can read it after the one-cycle pulse has gone
	always_comb begin
		cause_nxt = cause_r;
		if (cmd_wr_in) begin
			if (group_blocked) begin
				cause_nxt = group_cause;
			end else if (std_wp_ro_in) begin
				cause_nxt = ecwl_pkg::CAUSE_NONE;
			end
		end
	end

	// Refusal cause register
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cause_r <= ecwl_pkg::CAUSE_NONE;
		end else begin
			cause_r <= cause_nxt;
		end
	end

	// Read strobe of the lock word; other codes get no answer here,
	// since their owners answer reads of their own registers
	always_comb begin
		rd_valid_nxt = 1'b0;
		if (rd_lock_word) begin
			rd_valid_nxt = 1'b1;
		end
	end

	// Read strobe register
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_valid_nxt;
		end
	end

	// Read data holds between reads; the top bit is forced low
	always_comb begin
		rd_data_nxt = rd_data_r;
		if (rd_lock_word) begin
			rd_data_nxt = lock_image(lock_r);
		end
	end

	// Read data register
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_r <= ecwl_pkg::LW_RESET;
		end else begin
			rd_data_r <= rd_data_nxt;
		end
	end

	// Verdict outputs, straight from their flip-flops
	assign wr_accept_out = accept_r;
	assign wr_reject_out = reject_r;
	assign reject_cause_out = cause_r;

	// Read port outputs
	assign rd_valid_out = rd_valid_r;
	assign rd_data_out = rd_data_r;

	// Lock state as the host reads it and as the store path uses it;
	// the spare top bit is a constant, not logic
	assign lock_word_out = lock_image(lock_r);
	assign store_lock_active_out = store_eff_r;

endmodule

`default_nettype wire

// ==== logic/ecwl_pkg.sv ====
package ecwl_pkg;

	// Command codes of the lock word and the standard write protect
	localparam logic [7:0] CMD_LOCK_WORD     = 8'hDD;
	localparam logic [7:0] CMD_WRITE_PROTECT = 8'h10;

	// Commands guarded by the lock word
	localparam logic [7:0] CMD_OPERATION     = 8'h01;
	localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
	localparam logic [7:0] CMD_SECURITY_KEY  = 8'h0E;
	localparam logic [7:0] CMD_STORE_ALL     = 8'h15;
	localparam logic [7:0] CMD_RESTORE_ALL   = 8'h16;
	localparam logic [7:0] CMD_ALERT_MASK    = 8'h1B;
	localparam logic [7:0] CMD_VOUT_MODE     = 8'h20;
	localparam logic [7:0] CMD_VOUT_SETPOINT = 8'h21;
	localparam logic [7:0] CMD_VOUT_TRIM     = 8'h22;
	localparam logic [7:0] CMD_VOUT_MAX      = 8'h24;
	localparam logic [7:0] CMD_MARGIN_HIGH   = 8'h25;
	localparam logic [7:0] CMD_MARGIN_LOW    = 8'h26;
	localparam logic [7:0] CMD_TRANS_RATE    = 8'h27;
	localparam logic [7:0] CMD_SCALE_LOOP    = 8'h29;
	localparam logic [7:0] CMD_SCALE_MON     = 8'h2A;
	localparam logic [7:0] CMD_VOUT_MIN      = 8'h2B;
	localparam logic [7:0] CMD_FREQ_SWITCH   = 8'h33;
	localparam logic [7:0] CMD_VIN_ON        = 8'h35;
	localparam logic [7:0] CMD_VIN_OFF       = 8'h36;
	localparam logic [7:0] CMD_VOUT_OV_FLT   = 8'h40;
	localparam logic [7:0] CMD_VOUT_OV_RSP   = 8'h41;
	localparam logic [7:0] CMD_VOUT_OV_WRN   = 8'h42;
	localparam logic [7:0] CMD_VOUT_UV_WRN   = 8'h43;
	localparam logic [7:0] CMD_VOUT_UV_FLT   = 8'h44;
	localparam logic [7:0] CMD_VOUT_UV_RSP   = 8'h45;
	localparam logic [7:0] CMD_IOUT_OC_FLT   = 8'h46;
	localparam logic [7:0] CMD_IOUT_OC_RSP   = 8'h47;
	localparam logic [7:0] CMD_IOUT_OC_WRN   = 8'h4A;
	localparam logic [7:0] CMD_OT_FLT        = 8'h4F;
	localparam logic [7:0] CMD_OT_RSP        = 8'h50;
	localparam logic [7:0] CMD_OT_WRN        = 8'h51;
	localparam logic [7:0] CMD_VIN_OV_FLT    = 8'h55;
	localparam logic [7:0] CMD_TON_DELAY     = 8'h60;
	localparam logic [7:0] CMD_TON_RISE      = 8'h61;
	localparam logic [7:0] CMD_TOFF_DELAY    = 8'h64;
	localparam logic [7:0] CMD_TOFF_FALL     = 8'h65;
	localparam logic [7:0] CMD_MAKER_ID      = 8'h99;
	localparam logic [7:0] CMD_MAKER_MODEL   = 8'h9A;
	localparam logic [7:0] CMD_MAKER_REV     = 8'h9B;
	localparam logic [7:0] CMD_CUR_MON_CAL   = 8'hA4;
	localparam logic [7:0] CMD_BOOT_OFFSET   = 8'hE0;
	localparam logic [7:0] CMD_USER_SYS_CFG  = 8'hE1;
	localparam logic [7:0] CMD_BUS_ADDR      = 8'hE2;
	localparam logic [7:0] CMD_COMPENSATION  = 8'hE3;
	localparam logic [7:0] CMD_STACK_CFG     = 8'hE4;

	// Lock word layout
	localparam int LW_WIDTH        = 16;
	localparam int BIT_ZERO        = 15;
	localparam int BIT_PROTECT     = 14;
	localparam int BIT_TRIM        = 13;
	localparam int BIT_VOUT_SET    = 12;
	localparam int BIT_VOUT_FAULT  = 11;
	localparam int BIT_WARNING     = 10;
	localparam int BIT_CUR_TEMP    = 9;
	localparam int BIT_MARGIN      = 8;
	localparam int BIT_OPERATION   = 7;
	localparam int BIT_DEV_SETUP   = 6;
	localparam int BIT_VIN_FAULT   = 5;
	localparam int BIT_SEQUENCING  = 4;
	localparam int BIT_MAKER_DATA  = 3;
	localparam int BIT_SEC_KEY     = 2;
	localparam int BIT_RESTORE     = 1;
	localparam int BIT_STORE       = 0;

	// Values after reset, before the first load from non-volatile memory
	localparam logic [15:0] LW_RESET    = 16'h0000;
	localparam logic [15:0] LW_WR_MASK  = 16'h7FFF;
	localparam logic [3:0]  CAUSE_NONE  = 4'hF;

endpackage

// ==== logic/ecwl_group_decode.sv ====
`timescale 1ns/1ps
`default_nettype none

// Maps a command code to the one lock bit that guards it (one-hot).
module ecwl_group_decode (
	input  wire logic [7:0]  cmd_code_in,
	output logic      [15:0] guard_sel_out
);

	function automatic logic [15:0] guard_of(input logic [7:0] code);
		logic [15:0] sel;
		sel = 16'h0000;
		case (code)
			ecwl_pkg::CMD_LOCK_WORD, ecwl_pkg::CMD_WRITE_PROTECT:
				sel[ecwl_pkg::BIT_PROTECT] = 1'b1;
			ecwl_pkg::CMD_VOUT_TRIM, ecwl_pkg::CMD_CUR_MON_CAL,
			ecwl_pkg::CMD_SCALE_LOOP, ecwl_pkg::CMD_SCALE_MON,
			ecwl_pkg::CMD_BOOT_OFFSET:
				sel[ecwl_pkg::BIT_TRIM] = 1'b1;
			ecwl_pkg::CMD_VOUT_MODE, ecwl_pkg::CMD_VOUT_SETPOINT:
				sel[ecwl_pkg::BIT_VOUT_SET] = 1'b1;
			ecwl_pkg::CMD_VOUT_MAX, ecwl_pkg::CMD_VOUT_MIN,
			ecwl_pkg::CMD_VOUT_OV_FLT, ecwl_pkg::CMD_VOUT_OV_RSP,
			ecwl_pkg::CMD_VOUT_UV_FLT, ecwl_pkg::CMD_VOUT_UV_RSP:
				sel[ecwl_pkg::BIT_VOUT_FAULT] = 1'b1;
			ecwl_pkg::CMD_ALERT_MASK, ecwl_pkg::CMD_VOUT_OV_WRN,
			ecwl_pkg::CMD_VOUT_UV_WRN, ecwl_pkg::CMD_IOUT_OC_WRN,
			ecwl_pkg::CMD_OT_WRN:
				sel[ecwl_pkg::BIT_WARNING] = 1'b1;
			ecwl_pkg::CMD_IOUT_OC_FLT, ecwl_pkg::CMD_IOUT_OC_RSP,
			ecwl_pkg::CMD_OT_FLT, ecwl_pkg::CMD_OT_RSP:
				sel[ecwl_pkg::BIT_CUR_TEMP] = 1'b1;
			ecwl_pkg::CMD_MARGIN_HIGH, ecwl_pkg::CMD_MARGIN_LOW,
			ecwl_pkg::CMD_TRANS_RATE:
				sel[ecwl_pkg::BIT_MARGIN] = 1'b1;
			ecwl_pkg::CMD_OPERATION:
				sel[ecwl_pkg::BIT_OPERATION] = 1'b1;
			ecwl_pkg::CMD_FREQ_SWITCH, ecwl_pkg::CMD_USER_SYS_CFG,
			ecwl_pkg::CMD_BUS_ADDR, ecwl_pkg::CMD_COMPENSATION,
			ecwl_pkg::CMD_STACK_CFG:
				sel[ecwl_pkg::BIT_DEV_SETUP] = 1'b1;
			ecwl_pkg::CMD_VIN_OV_FLT:
				sel[ecwl_pkg::BIT_VIN_FAULT] = 1'b1;
			ecwl_pkg::CMD_TON_DELAY, ecwl_pkg::CMD_TON_RISE,
			ecwl_pkg::CMD_TOFF_DELAY, ecwl_pkg::CMD_TOFF_FALL,
			ecwl_pkg::CMD_ON_OFF_CONFIG, ecwl_pkg::CMD_VIN_ON,
			ecwl_pkg::CMD_VIN_OFF:
				sel[ecwl_pkg::BIT_SEQUENCING] = 1'b1;
			ecwl_pkg::CMD_MAKER_ID, ecwl_pkg::CMD_MAKER_MODEL,
			ecwl_pkg::CMD_MAKER_REV:
				sel[ecwl_pkg::BIT_MAKER_DATA] = 1'b1;
			ecwl_pkg::CMD_SECURITY_KEY:
				sel[ecwl_pkg::BIT_SEC_KEY] = 1'b1;
			ecwl_pkg::CMD_RESTORE_ALL:
				sel[ecwl_pkg::BIT_RESTORE] = 1'b1;
			ecwl_pkg::CMD_STORE_ALL:
				sel[ecwl_pkg::BIT_STORE] = 1'b1;
			default:
				sel = 16'h0000;
		endcase
		return sel;
	endfunction

	// Purely combinational; the top registers every decision
	assign guard_sel_out = guard_of(cmd_code_in);

endmodule

`default_nettype wire

// ==== testbench/ecwl_filter_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the filter ports only
module ecwl_filter_asserts (
	input wire logic        sys_clk_in,
	input wire logic        rst_in,
	input wire logic        cmd_wr_in,
	input wire logic        cmd_rd_in,
	input wire logic [7:0]  cmd_code_in,
	input wire logic [15:0] cmd_wdata_in,
	input wire logic        std_wp_ro_in,
	input wire logic        nvm_load_in,
	input wire logic [15:0] nvm_word_in,
	input wire logic        wr_accept_out,
	input wire logic        wr_reject_out,
	input wire logic [3:0]  reject_cause_out,
	input wire logic        rd_valid_out,
	input wire logic [15:0] rd_data_out,
	input wire logic [15:0] lock_word_out,
	input wire logic        store_lock_active_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// Every write gets exactly one verdict, nothing else does
	property p_answer;
		cmd_wr_in |=> wr_accept_out != wr_reject_out;
	endproperty
	property p_quiet;
		!cmd_wr_in |=> !wr_accept_out && !wr_reject_out;
	endproperty
	property p_std;
		cmd_wr_in && std_wp_ro_in |=> wr_reject_out;
	endproperty
	property p_zero;
		1'b1 |-> !rd_data_out[15] && !lock_word_out[15];
	endproperty
	property p_read;
		cmd_rd_in && cmd_code_in == 8'hDD |=> rd_valid_out;
	endproperty
	property p_load;
		nvm_load_in |=> lock_word_out == ($past(nvm_word_in) & 16'h7FFF);
	endproperty
	property p_active;
		nvm_load_in |=> {15'h0000, store_lock_active_out} ==
			($past(nvm_word_in) & 16'h0001);
	endproperty
	// Protect bit may only go away through a load
	property p_wpl;
		lock_word_out[14] && !nvm_load_in |=> lock_word_out[14];
	endproperty
	property p_store;
		cmd_wr_in && cmd_code_in == 8'h15 && store_lock_active_out &&
			!std_wp_ro_in |=> wr_reject_out && reject_cause_out == 4'h0;
	endproperty
	property p_write;
		cmd_wr_in && cmd_code_in == 8'hDD && !lock_word_out[14] &&
			!std_wp_ro_in && !nvm_load_in
			|=> lock_word_out == ($past(cmd_wdata_in) & 16'h7FFF);
	endproperty
	a_answer: assert property (p_answer) else $error("no verdict");
	a_quiet: assert property (p_quiet) else $error("stray verdict");
	a_std: assert property (p_std) else $error("protect ignored");
	a_zero: assert property (p_zero) else $error("top bit set");
	a_read: assert property (p_read) else $error("no read answer");
	a_load: assert property (p_load) else $error("load lost");
	a_active: assert property (p_active) else $error("store copy");
	a_wpl: assert property (p_wpl) else $error("protect cleared");
	a_store: assert property (p_store) else $error("store passed");
	a_write: assert property (p_write) else $error("word lost");
	c_group: cover property (wr_reject_out && reject_cause_out == 4'h1);
	c_active: cover property (store_lock_active_out);
	c_wpl: cover property (lock_word_out[14]);
endmodule
bind ecwl_filter ecwl_filter_asserts u_chk (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cmd_wr_in(cmd_wr_in),
	.cmd_rd_in(cmd_rd_in), .cmd_code_in(cmd_code_in),
	.cmd_wdata_in(cmd_wdata_in), .std_wp_ro_in(std_wp_ro_in),
	.nvm_load_in(nvm_load_in), .nvm_word_in(nvm_word_in),
	.wr_accept_out(wr_accept_out), .wr_reject_out(wr_reject_out),
	.reject_cause_out(reject_cause_out), .rd_valid_out(rd_valid_out),
	.rd_data_out(rd_data_out), .lock_word_out(lock_word_out),
	.store_lock_active_out(store_lock_active_out));
`default_nettype wire

// ==== testbench/ecwl_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Bus host: one whole-word request per call
module ecwl_host_model (
	input  wire logic        sys_clk_in,
	output logic             wr_out,
	output logic             rd_out,
	output logic      [7:0]  code_out,
	output logic      [15:0] wdata_out
);
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		code_out = 8'h00;
		wdata_out = 16'h0000;
	end
	// Hold through the taking edge; idle lines carry junk, not stale data
	task automatic req(input logic w, input logic [7:0] c,
			input logic [15:0] d);
		@(posedge sys_clk_in);
		#1;
		wr_out = w;
		rd_out = !w;
		code_out = c;
		wdata_out = d;
		@(posedge sys_clk_in);
		#1;
		wr_out = 1'b0;
		rd_out = 1'b0;
		code_out = ~c;
		wdata_out = ~d;
	endtask
endmodule
`default_nettype wire

// ==== testbench/extended_command_write_lock_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module extended_command_write_lock_tb_top;
	logic        sys_clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        wr, rd, acc, rej, vld, act;
	logic        wp = 1'b0;
	logic        ld = 1'b0;
	logic [7:0]  code;
	logic [3:0]  cause;
	logic [15:0] wdata, rdata, lword;
	logic [15:0] nword = 16'h0000;
	int          errors = 0;
	int          total_checks = 0;
	always #12.5 sys_clk_in = ~sys_clk_in;
	ecwl_host_model host (.sys_clk_in(sys_clk_in), .wr_out(wr),
		.rd_out(rd), .code_out(code), .wdata_out(wdata));
	ecwl_filter dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.cmd_wr_in(wr), .cmd_rd_in(rd), .cmd_code_in(code),
		.cmd_wdata_in(wdata), .std_wp_ro_in(wp), .nvm_load_in(ld),
		.nvm_word_in(nword), .wr_accept_out(acc), .wr_reject_out(rej),
		.reject_cause_out(cause), .rd_valid_out(vld),
		.rd_data_out(rdata), .lock_word_out(lword),
		.store_lock_active_out(act));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Verdict of one write, and the cause when refused
	task automatic wrc(input logic [7:0] c, input logic [15:0] d,
			input logic ok, input logic [3:0] cs);
		host.req(1'b1, c, d);
		chk({14'h0000, acc, rej}, {14'h0000, ok, !ok});
		if (!ok) chk({12'h000, cause}, {12'h000, cs});
	endtask
	task automatic load(input logic [15:0] w);
		@(posedge sys_clk_in);
		#1;
		ld = 1'b1;
		nword = w;
		@(posedge sys_clk_in);
		#1;
		ld = 1'b0;
		nword = ~w;
	endtask
	// Each of group bits 1 to 13 alone refuses its command, names itself, spares the next group's command
	task automatic s_groups();
		logic [7:0] cd [13:1] = '{8'h22, 8'h21, 8'h24, 8'h1B, 8'h46,
			8'h25, 8'h01, 8'h33, 8'h55, 8'h60, 8'h99, 8'h0E, 8'h16};
		for (int b = 1; b <= 13; b++) begin
			wrc(8'hDD, 16'h0001 << b, 1'b1, 4'h0);
			wrc(cd[b], 16'h1234, 1'b0, 4'(b));
			wrc(cd[b == 13 ? 1 : b + 1], 16'h1234, 1'b1, 4'h0);
		end
		wrc(8'hDD, 16'h0000, 1'b1, 4'h0);
		wp = 1'b1;
		wrc(8'h01, 16'h0000, 1'b0, 4'hF);
		wp = 1'b0;
		wrc(8'h01, 16'h0000, 1'b1, 4'h0);
	endtask
	// Store lock only after a load; load not stopped by restore lock
	task automatic s_store();
		wrc(8'hDD, 16'h0003, 1'b1, 4'h0);
		chk(lword, 16'h0003);
		chk({15'h0000, act}, 16'h0000);
		wrc(8'h15, 16'h0000, 1'b1, 4'h0);
		load(16'h0001);
		chk(lword, 16'h0001);
		chk({15'h0000, act}, 16'h0001);
		wrc(8'h15, 16'h0000, 1'b0, 4'h0);
		load(16'h0000);
	endtask
	// Top bit reads zero; protect bit freezes both protect words
	task automatic s_top();
		wrc(8'hDD, 16'hC000, 1'b1, 4'h0);
		host.req(1'b0, 8'hDD, 16'h0000);
		chk(rdata, 16'h4000);
		chk({15'h0000, vld}, 16'h0001);
		host.req(1'b0, 8'h10, 16'h0000);
		chk({15'h0000, vld}, 16'h0000);
		wrc(8'hDD, 16'h0000, 1'b0, 4'hE);
		wrc(8'h10, 16'h0000, 1'b0, 4'hE);
		chk(lword, 16'h4000);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge sys_clk_in);
		#1;
		rst_in = 1'b0;
		s_groups();
		s_store();
		s_top();
		tally_and_finish();
	end
	// Run needs about 130 cycles; a limit of 3000 allows ample margin
	initial begin
		#(25 * 3000);
		errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
